// File: design/ctp_consts.vh
// Constants for the transfer and priority unit: opcodes, selects, resets.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CTP_CONSTS_VH
`define CTP_CONSTS_VH

// ----------------------------------------------------------------------
// Step opcodes on instr_op
// ----------------------------------------------------------------------
`define CTP_OP_XFER 4'h0
`define CTP_OP_A2S 4'h1
`define CTP_OP_S2A 4'h2
`define CTP_OP_A2D 4'h3
`define CTP_OP_D2A 4'h4
`define CTP_OP_MVF 4'h5
`define CTP_OP_MVB 4'h6
`define CTP_OP_TO_EMU 4'h7
`define CTP_OP_TO_NAT 4'h8
`define CTP_OP_SETW 4'h9

// ----------------------------------------------------------------------
// Source and destination selects for a generic transfer
// ----------------------------------------------------------------------
`define CTP_SRC_ACC 3'h0
`define CTP_SRC_X 3'h1
`define CTP_SRC_Y 3'h2
`define CTP_SRC_S 3'h3
`define CTP_SRC_D 3'h4
`define CTP_SRC_IMM 3'h5
`define CTP_DST_ACC 2'h0
`define CTP_DST_X 2'h1
`define CTP_DST_Y 2'h2

// ----------------------------------------------------------------------
// Width-select field positions in instr_byte2 for the width step
// ----------------------------------------------------------------------
`define CTP_SETW_M_BIT 5
`define CTP_SETW_X_BIT 4

// ----------------------------------------------------------------------
// Service source codes, highest priority first
// ----------------------------------------------------------------------
`define CTP_SVC_RESTART 2'h0
`define CTP_SVC_ABORT 2'h1
`define CTP_SVC_NMI 2'h2
`define CTP_SVC_IRQ 2'h3

// ----------------------------------------------------------------------
// Reset and forced values
// ----------------------------------------------------------------------
`define CTP_STACK_HI_EMU 8'h01
`define CTP_IDX_HI_EMU 8'h00
`define CTP_RST_WORD 16'h0000
`define CTP_RST_STACK 16'h01ff
`define CTP_RST_BYTE 8'h00

`endif

// File: design/ctp_irq_pri.v
// Interrupt pending latches and fixed priority pick at instruction boundaries.
// Assumes inputs synchronous to clock; boundary is a one-cycle pulse.
`include "ctp_consts.vh"

module ctp_irq_pri (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Sources and gating
    input wire restart_in,
    input wire abort_in,
    input wire nmi_in,
    input wire irq_in,
    input wire irq_mask,
    input wire boundary,
    // Service answer
    output reg svc_valid_r,
    output reg [1:0] svc_src_r
);

    // ------------------------------------------------------------------
    // Sticky latches for restart, abort and edge-caught nmi
    // ------------------------------------------------------------------
    reg [2:0] pend_r;
    reg nmi_prev_r;
    wire [2:0] set_w;
    wire [2:0] take_w;
    wire irq_live;

    assign set_w = {nmi_in & ~nmi_prev_r, abort_in, restart_in};
    assign irq_live = irq_in & ~irq_mask;
    // Only the highest pending one is taken; the rest stay latched
    assign take_w[0] = boundary & pend_r[0];
    assign take_w[1] = boundary & pend_r[1] & ~pend_r[0];
    assign take_w[2] = boundary & pend_r[2] & ~pend_r[1] & ~pend_r[0];

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nmi_prev_r <= 1'b0;
        end else begin
            nmi_prev_r <= nmi_in;
        end
    end

    // Set beats clear so an event landing on its own service is kept
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_pend
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    pend_r[gi] <= 1'b0;
                end else begin
                    pend_r[gi] <= (pend_r[gi] & ~take_w[gi]) | set_w[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Service pulse; irq is a level and stays pending while held
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            svc_valid_r <= 1'b0;
            svc_src_r <= `CTP_SVC_RESTART;
        end else begin
            svc_valid_r <= boundary & ((|pend_r) | irq_live);
            if (take_w[0]) begin
                svc_src_r <= `CTP_SVC_RESTART;
            end else if (take_w[1]) begin
                svc_src_r <= `CTP_SVC_ABORT;
            end else if (take_w[2]) begin
                svc_src_r <= `CTP_SVC_NMI;
            end else if (boundary & irq_live) begin
                svc_src_r <= `CTP_SVC_IRQ;
            end
        end
    end

endmodule // ctp_irq_pri

// File: design/ctp_core.v
// Register transfer datapath, write-cycle hold and interrupt priority unit.
// Assumes a sequencer that issues one step per instr_valid pulse and that
// the memory side drives ready synchronously with clock.
`include "ctp_consts.vh"

module ctp_core (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Instruction step from the sequencer
    input wire instr_valid,
    input wire [3:0] instr_op,
    input wire [2:0] instr_src,
    input wire [1:0] instr_dst,
    input wire [7:0] instr_byte2,
    input wire [15:0] instr_imm,
    // Write cycle toward memory
    input wire wr_start,
    input wire [23:0] wr_addr,
    input wire [7:0] wr_data,
    input wire ready,
    output reg mem_we_r,
    output reg [23:0] mem_addr_r,
    output reg [7:0] mem_wdata_r,
    output reg wr_done_r,
    // Interrupt sources
    input wire restart_in,
    input wire abort_in,
    input wire nmi_in,
    input wire irq_in,
    input wire irq_mask,
    input wire boundary,
    output wire svc_valid_r,
    output wire [1:0] svc_src_r,
    // Register state
    output reg [15:0] acc_r,
    output reg [15:0] idx_x_r,
    output reg [15:0] idx_y_r,
    output reg [15:0] stack_r,
    output reg [15:0] direct_r,
    output reg [7:0] bank_r,
    output reg emu_r,
    output reg m_flag_r,
    output reg x_flag_r,
    output reg neg_r,
    output reg zero_r,
    output reg [15:0] xfer_bus_r,
    output reg instr_done_r
);

    // ------------------------------------------------------------------
    // Write cycle hold
    // ------------------------------------------------------------------
    wire wr_finish;
    wire step_ok;

    assign wr_finish = mem_we_r & ready;
    // Steps offered while a write is open are dropped, so the core is truly halted
    assign step_ok = instr_valid & ~mem_we_r;

    // The cycle stays on the pins until ready returns high
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_we_r <= 1'b0;
            mem_addr_r <= 24'h00_0000;
            mem_wdata_r <= `CTP_RST_BYTE;
            wr_done_r <= 1'b0;
        end else begin
            wr_done_r <= wr_finish;
            if (mem_we_r) begin
                mem_we_r <= ~ready;
            end else if (wr_start) begin
                mem_we_r <= 1'b1;
                mem_addr_r <= wr_addr;
                mem_wdata_r <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Source select: always the full sixteen bits
    // ------------------------------------------------------------------
    reg [15:0] src_val;

    always @* begin
        case (instr_src)
            `CTP_SRC_ACC: src_val = acc_r;
            `CTP_SRC_X: src_val = idx_x_r;
            `CTP_SRC_Y: src_val = idx_y_r;
            `CTP_SRC_S: src_val = stack_r;
            `CTP_SRC_D: src_val = direct_r;
            `CTP_SRC_IMM: src_val = instr_imm;
            default: src_val = `CTP_RST_WORD;
        endcase
    end

    // Destination width: accumulator follows m, index follows x
    wire dst_narrow;
    wire [15:0] xfer_val;

    assign dst_narrow = (instr_dst == `CTP_DST_ACC) ? m_flag_r : x_flag_r;
    // Per-step value placed on the internal path
    assign xfer_val = (instr_op == `CTP_OP_XFER) ? src_val :
                      (instr_op == `CTP_OP_S2A) ? stack_r :
                      (instr_op == `CTP_OP_D2A) ? direct_r : acc_r;

    // ------------------------------------------------------------------
    // Register file and flags
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= `CTP_RST_WORD;
            idx_x_r <= `CTP_RST_WORD;
            idx_y_r <= `CTP_RST_WORD;
            stack_r <= `CTP_RST_STACK;
            direct_r <= `CTP_RST_WORD;
            bank_r <= `CTP_RST_BYTE;
            emu_r <= 1'b1;
            m_flag_r <= 1'b1;
            x_flag_r <= 1'b1;
            neg_r <= 1'b0;
            zero_r <= 1'b0;
            xfer_bus_r <= `CTP_RST_WORD;
            instr_done_r <= 1'b0;
        end else begin
            instr_done_r <= step_ok;
            if (step_ok) begin
                xfer_bus_r <= xfer_val;
                case (instr_op)
                    `CTP_OP_XFER: begin
                        // Narrow target keeps its high byte untouched
                        case (instr_dst)
                            `CTP_DST_ACC: begin
                                if (dst_narrow) begin
                                    acc_r[7:0] <= src_val[7:0];
                                end else begin
                                    acc_r <= src_val;
                                end
                            end
                            `CTP_DST_X: begin
                                if (dst_narrow) begin
                                    idx_x_r[7:0] <= src_val[7:0];
                                end else begin
                                    idx_x_r <= src_val;
                                end
                            end
                            `CTP_DST_Y: begin
                                if (dst_narrow) begin
                                    idx_y_r[7:0] <= src_val[7:0];
                                end else begin
                                    idx_y_r <= src_val;
                                end
                            end
                            default: begin
                                acc_r <= acc_r;
                            end
                        endcase
                        if (instr_dst != 2'h3) begin
                            neg_r <= dst_narrow ? src_val[7] : src_val[15];
                            zero_r <= dst_narrow ? (src_val[7:0] == 8'h00) :
                                      (src_val == 16'h0000);
                        end
                    end
                    `CTP_OP_A2S: begin
                        // Emulation keeps page one; native takes the upper byte
                        if (emu_r) begin
                            stack_r <= {`CTP_STACK_HI_EMU, acc_r[7:0]};
                        end else begin
                            stack_r <= acc_r;
                        end
                    end
                    `CTP_OP_S2A: begin
                        acc_r <= stack_r;
                        neg_r <= stack_r[15];
                        zero_r <= (stack_r == 16'h0000);
                    end
                    `CTP_OP_A2D: begin
                        direct_r <= acc_r;
                        neg_r <= acc_r[15];
                        zero_r <= (acc_r == 16'h0000);
                    end
                    `CTP_OP_D2A: begin
                        acc_r <= direct_r;
                        neg_r <= direct_r[15];
                        zero_r <= (direct_r == 16'h0000);
                    end
                    `CTP_OP_MVF, `CTP_OP_MVB: begin
                        bank_r <= instr_byte2;
                    end
                    `CTP_OP_TO_EMU: begin
                        // Low bytes and the accumulator survive the switch
                        emu_r <= 1'b1;
                        m_flag_r <= 1'b1;
                        x_flag_r <= 1'b1;
                        stack_r[15:8] <= `CTP_STACK_HI_EMU;
                        idx_x_r[15:8] <= `CTP_IDX_HI_EMU;
                        idx_y_r[15:8] <= `CTP_IDX_HI_EMU;
                    end
                    `CTP_OP_TO_NAT: begin
                        emu_r <= 1'b0;
                    end
                    `CTP_OP_SETW: begin
                        // Widths are locked narrow in emulation
                        if (!emu_r) begin
                            m_flag_r <= instr_byte2[`CTP_SETW_M_BIT];
                            x_flag_r <= instr_byte2[`CTP_SETW_X_BIT];
                            if (instr_byte2[`CTP_SETW_X_BIT]) begin
                                idx_x_r[15:8] <= `CTP_IDX_HI_EMU;
                                idx_y_r[15:8] <= `CTP_IDX_HI_EMU;
                            end
                        end
                    end
                    default: begin
                        acc_r <= acc_r;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt priority
    // ------------------------------------------------------------------
    ctp_irq_pri u_irq_pri (
        .clock(clock),
        .rst_n(rst_n),
        .restart_in(restart_in),
        .abort_in(abort_in),
        .nmi_in(nmi_in),
        .irq_in(irq_in),
        .irq_mask(irq_mask),
        .boundary(boundary),
        .svc_valid_r(svc_valid_r),
        .svc_src_r(svc_src_r)
    );

endmodule // ctp_core

// File: tb/ctp_core_checker.sv
// Checker for the transfer and priority unit, bound to ctp_core.
// Assumes one clock domain with the active-low asynchronous reset.
`include "ctp_consts.vh"
module ctp_core_checker (
    // Clock and reset
    input logic clock,
    input logic rst_n,
    // Requests
    input logic instr_valid,
    input logic [3:0] instr_op,
    input logic [7:0] instr_byte2,
    input logic ready,
    input logic restart_in,
    input logic boundary,
    // Results
    input logic mem_we_r,
    input logic [23:0] mem_addr_r,
    input logic [7:0] mem_wdata_r,
    input logic wr_done_r,
    input logic instr_done_r,
    input logic svc_valid_r,
    input logic [1:0] svc_src_r,
    input logic [15:0] acc_r,
    input logic [15:0] idx_x_r,
    input logic [15:0] idx_y_r,
    input logic [15:0] stack_r,
    input logic [15:0] direct_r,
    input logic [7:0] bank_r,
    input logic emu_r,
    input logic m_flag_r,
    input logic x_flag_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Properties
    // ----
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // A step counts only when no write holds the core
    wire step = instr_valid && !mem_we_r;
    wire [7:0] acc_lo = acc_r[7:0];
    wire [7:0] acc_hi = acc_r[15:8];
    property p_hold;
        mem_we_r && !ready |=> mem_we_r && $stable(mem_addr_r) && $stable(mem_wdata_r);
    endproperty
    a_hold: assert property (p_hold) else $error("write not held");
    property p_done;
        mem_we_r && ready |=> !mem_we_r && wr_done_r;
    endproperty
    a_done: assert property (p_done) else $error("write not closed");
    property p_halt;
        mem_we_r && instr_valid |=> !instr_done_r;
    endproperty
    a_halt: assert property (p_halt) else $error("step ran during write");
    property p_bank;
        step && (instr_op == `CTP_OP_MVF || instr_op == `CTP_OP_MVB) |=> bank_r == $past(instr_byte2);
    endproperty
    a_bank: assert property (p_bank) else $error("bank not loaded");
    property p_pri;
        restart_in ##1 boundary |=> svc_valid_r && svc_src_r == `CTP_SVC_RESTART;
    endproperty
    a_pri: assert property (p_pri) else $error("restart not first");
    property p_a2s;
        step && instr_op == `CTP_OP_A2S |=> stack_r[7:0] == $past(acc_lo)
            && stack_r[15:8] == ($past(emu_r) ? 8'h01 : $past(acc_hi));
    endproperty
    a_a2s: assert property (p_a2s) else $error("stack move wrong");
    property p_s2a;
        step && instr_op == `CTP_OP_S2A |=> acc_r == $past(stack_r);
    endproperty
    a_s2a: assert property (p_s2a) else $error("stack to acc wrong");
    property p_a2d;
        step && instr_op == `CTP_OP_A2D |=> direct_r == $past(acc_r);
    endproperty
    a_a2d: assert property (p_a2d) else $error("direct move wrong");
    property p_emu;
        step && instr_op == `CTP_OP_TO_EMU |=> emu_r && m_flag_r && x_flag_r
            && idx_x_r[15:8] == 8'h00 && idx_y_r[15:8] == 8'h00 && stack_r[15:8] == 8'h01;
    endproperty
    a_emu: assert property (p_emu) else $error("mode entry wrong");
    // Main scenarios reached
    c_stall: cover property (mem_we_r && !ready);
    c_bank: cover property (step && instr_op == `CTP_OP_MVB);
    c_irq: cover property (svc_valid_r && svc_src_r == `CTP_SVC_IRQ);
endmodule // ctp_core_checker

// File: tb/ctp_mem_resp.sv
// Memory side responder: answers an open write after a chosen stall.
// Assumes the core holds mem_we_r until ready is sampled high.
module ctp_mem_resp (
    // Clock and reset
    input logic clock,
    input logic rst_n,
    // Core side
    input logic mem_we_r,
    input logic [3:0] stall,
    output logic ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_r;
    logic idle_r;
    // Idle ready toggles so no stale level is ever trusted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 4'h0;
            idle_r <= 1'b0;
        end else begin
            wait_r <= mem_we_r ? wait_r + 4'h1 : 4'h0;
            idle_r <= ~idle_r;
        end
    end
    assign ready = mem_we_r ? (wait_r >= stall) : idle_r;
endmodule // ctp_mem_resp

// File: tb/ctp_core_bench.sv
// Self-checking bench for ctp_core against a register-level model.
// Assumes the memory responder and checker files compile first.
`include "ctp_consts.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module ctp_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0, instr_valid = 0, wr_start = 0, boundary = 0;
    logic restart_in = 0, abort_in = 0, nmi_in = 0, irq_in = 0, irq_mask = 0;
    logic [3:0] instr_op = 0, stall = 0;
    logic [2:0] instr_src = 0;
    logic [1:0] instr_dst = 0;
    logic [7:0] instr_byte2 = 0, wr_data = 0;
    logic [15:0] instr_imm = 0;
    logic [23:0] wr_addr = 0;
    wire ready, mem_we_r, wr_done_r, svc_valid_r, instr_done_r;
    wire emu_r, m_flag_r, x_flag_r, neg_r, zero_r;
    wire [23:0] mem_addr_r;
    wire [7:0] mem_wdata_r, bank_r;
    wire [1:0] svc_src_r;
    wire [15:0] acc_r, idx_x_r, idx_y_r, stack_r, direct_r, xfer_bus_r;
    int n_errors = 0, checked = 0, cyc = 0, i;
    integer seed = 32'hde9c_c6be;
    logic [15:0] ma, mx, my, ms, md;
    logic [7:0] mb;
    logic me, mm, mxf, mn, mz;
    wire [92:0] dut_st = {acc_r, idx_x_r, idx_y_r, stack_r, direct_r, bank_r,
        emu_r, m_flag_r, x_flag_r, neg_r, zero_r};
    ctp_core uut (.clock, .rst_n, .instr_valid, .instr_op, .instr_src, .instr_dst,
        .instr_byte2, .instr_imm, .wr_start, .wr_addr, .wr_data, .ready, .mem_we_r,
        .mem_addr_r, .mem_wdata_r, .wr_done_r, .restart_in, .abort_in, .nmi_in, .irq_in,
        .irq_mask, .boundary, .svc_valid_r, .svc_src_r, .acc_r, .idx_x_r, .idx_y_r,
        .stack_r, .direct_r, .bank_r, .emu_r, .m_flag_r, .x_flag_r, .neg_r, .zero_r,
        .xfer_bus_r, .instr_done_r);
    ctp_mem_resp u_mem (.clock, .rst_n, .mem_we_r, .stall, .ready);
    // ----
    // Clock, timeout, model helpers
    // ----
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            wrap_up();
        end
    end
    function automatic logic [92:0] mod_st;
        return {ma, mx, my, ms, md, mb, me, mm, mxf, mn, mz};
    endfunction
    // Narrow destinations keep their high byte
    function automatic logic [15:0] nw(input logic [15:0] o, n, input logic nar);
        return nar ? {o[15:8], n[7:0]} : n;
    endfunction
    task automatic nz(input logic [15:0] v, input logic nar);
        mn = nar ? v[7] : v[15];
        mz = nar ? (v[7:0] == 8'h00) : (v == 16'h0000);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One step: model first, then drive and compare
    task automatic do_step(input logic [31:0] r);
        logic [3:0] op;
        logic [15:0] v;
        logic nar, cb;
        op = 4'(r % 10);
        cb = (op <= `CTP_OP_D2A);
        v = 16'h0000;
        nar = (r[9:8] == `CTP_DST_ACC) ? mm : mxf;
        case (op)
            `CTP_OP_XFER: begin
                case (r[6:4])
                    `CTP_SRC_ACC: v = ma;
                    `CTP_SRC_X: v = mx;
                    `CTP_SRC_Y: v = my;
                    `CTP_SRC_S: v = ms;
                    `CTP_SRC_D: v = md;
                    `CTP_SRC_IMM: v = r[31:16];
                    default: v = 16'h0000;
                endcase
                if (r[9:8] != 2'h3) nz(v, nar);
                if (r[9:8] == `CTP_DST_ACC) ma = nw(ma, v, nar);
                if (r[9:8] == `CTP_DST_X) mx = nw(mx, v, nar);
                if (r[9:8] == `CTP_DST_Y) my = nw(my, v, nar);
            end
            `CTP_OP_A2S: begin v = ma; ms = me ? {8'h01, ma[7:0]} : ma; end
            `CTP_OP_S2A: begin v = ms; ma = v; nz(v, 0); end
            `CTP_OP_A2D: begin v = ma; md = v; nz(v, 0); end
            `CTP_OP_D2A: begin v = md; ma = v; nz(v, 0); end
            `CTP_OP_MVF, `CTP_OP_MVB: mb = r[23:16];
            `CTP_OP_TO_EMU: begin
                {me, mm, mxf} = 3'h7;
                ms[15:8] = 8'h01;
                mx[15:8] = 8'h00;
                my[15:8] = 8'h00;
            end
            `CTP_OP_TO_NAT: me = 0;
            default: if (!me) begin
                mm = r[`CTP_SETW_M_BIT + 16];
                mxf = r[`CTP_SETW_X_BIT + 16];
                if (mxf) begin mx[15:8] = 8'h00; my[15:8] = 8'h00; end
            end
        endcase
        @(posedge clock);
        instr_valid <= 1;
        instr_op <= op;
        instr_src <= r[6:4];
        instr_dst <= r[9:8];
        instr_byte2 <= r[23:16];
        instr_imm <= r[31:16];
        @(posedge clock);
        instr_valid <= 0;
        #1 `CHK("done", 1'b1, instr_done_r)
        `CHK("regs", mod_st(), dut_st)
        if (cb) `CHK("bus", v, xfer_bus_r)
    endtask
    // Write with stall; a step offered meanwhile must be dropped
    task automatic do_write(input logic [31:0] r, input int s);
        int n;
        @(posedge clock);
        stall <= 4'(s);
        wr_start <= 1;
        wr_addr <= r[23:0];
        wr_data <= r[31:24];
        @(posedge clock);
        wr_start <= 0;
        instr_valid <= 1;
        instr_op <= `CTP_OP_D2A;
        #1 `CHK("addr", r[23:0], mem_addr_r)
        `CHK("data", r[31:24], mem_wdata_r)
        n = 0;
        do begin
            @(posedge clock);
            instr_valid <= 0;
            #1 n++;
        end while (wr_done_r !== 1'b1 && n < 40);
        `CHK("latency", s + 1, n)
        `CHK("halted", mod_st(), dut_st)
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        {ma, mx, my, md, mb, mn, mz} = 0;
        ms = 16'h01ff;
        {me, mm, mxf} = 3'h7;
        repeat (10) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        #1 `CHK("reset", mod_st(), dut_st)
        $display("reset test done");
        for (i = 0; i < 300; i++) do_step($random(seed));
        $display("step test done");
        for (i = 0; i < 6; i++) do_write($random(seed), i % 5);
        $display("write test done");
        @(posedge clock);
        {restart_in, abort_in, nmi_in, irq_in} <= 4'hf;
        @(posedge clock);
        {restart_in, abort_in, nmi_in} <= 3'h0;
        for (i = 0; i < 4; i++) begin
            boundary <= 1;
            @(posedge clock);
            boundary <= 0;
            #1 `CHK("svc", 1'b1, svc_valid_r)
            `CHK("src", 2'(i), svc_src_r)
            @(posedge clock);
        end
        irq_mask <= 1;
        boundary <= 1;
        @(posedge clock);
        boundary <= 0;
        #1 `CHK("masked", 1'b0, svc_valid_r)
        $display("priority test done");
        wrap_up();
    end
endmodule // ctp_core_bench
bind ctp_core ctp_core_checker u_chk (.clock, .rst_n, .instr_valid, .instr_op, .instr_byte2,
    .ready, .restart_in, .boundary, .mem_we_r, .mem_addr_r, .mem_wdata_r, .wr_done_r,
    .instr_done_r, .svc_valid_r, .svc_src_r, .acc_r, .idx_x_r, .idx_y_r, .stack_r,
    .direct_r, .bank_r, .emu_r, .m_flag_r, .x_flag_r);
